/* File: core/gdi_gate_drive.sv */
/*
 * Input-side logic of a two-channel gate driver: mode select between
 * half-bridge with dead time and direct drive, per-channel blocking after
 * faults, error memories, open-drain status outputs and status LEDs.
 * Assumes all pin inputs are asynchronous and the channel-side fault and
 * supply indications arrive as plain levels.
 */

`timescale 1ns/10ps
module gdi_gate_drive
	import gdi_pkg::*;
#(
	parameter int unsigned P_BLOCK_CYC = BLOCK_CYC_DEF
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_drive_input_a,
	input wire logic i_drive_input_b,
	input wire logic i_topology_sel,
	input wire logic i_fault_clear_n,
	input wire logic i_sat_fault_ch1,
	input wire logic i_sat_fault_ch2,
	input wire logic i_uv_fault_ch1,
	input wire logic i_uv_fault_ch2,
	input wire logic i_converter_supply_ch1,
	input wire logic i_converter_supply_ch2,
	output logic o_gate_ch1,
	output logic o_gate_ch2,
	output logic o_fault_flag_ch1_o,
	output logic o_fault_flag_ch1_oe,
	output logic o_fault_flag_ch2_o,
	output logic o_fault_flag_ch2_oe,
	output logic o_led_ch1,
	output logic o_led_ch2
);

	localparam logic [BLK_W-1:0] BLOCK_CYC = P_BLOCK_CYC[BLK_W-1:0];

	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] syn;
	logic pwm;
	logic enable;
	logic direct;
	logic clr_n;
	logic [1:0] drive;
	logic [1:0] sat;
	logic [1:0] uv;
	logic [1:0] sup;

	assign raw = {i_converter_supply_ch2, i_converter_supply_ch1, i_uv_fault_ch2, i_uv_fault_ch1,
		i_sat_fault_ch2, i_sat_fault_ch1, i_fault_clear_n, i_topology_sel,
		i_drive_input_b, i_drive_input_a};

	// Reset levels stand in for the pull resistors of open pins
	gdi_sync3 #(
		.W(SY_W),
		.RST(SY_RST)
	) u_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d(raw),
		.o_q(syn)
	);

	assign direct = syn[SY_MODE];
	assign pwm = syn[SY_A];
	assign enable = syn[SY_B];
	assign clr_n = syn[SY_CLR_N];
	assign drive = {syn[SY_B], syn[SY_A]};
	assign sat = {syn[SY_SAT2], syn[SY_SAT1]};
	assign uv = {syn[SY_UV2], syn[SY_UV1]};
	assign sup = {syn[SY_SUP2], syn[SY_SUP1]};

	// Drive edge detection
	logic [1:0] drive_prev_reg;
	logic [1:0] drive_prev_next;
	logic edge_seen;

	always_comb
	begin
		drive_prev_next = drive;
		edge_seen = |(drive ^ drive_prev_reg);
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			drive_prev_reg <= SY_RST[1:0];
		else
			drive_prev_reg <= drive_prev_next;
	end

	// Half-bridge sequencer with dead-time insertion
	gdi_hb_state_t hb_reg;
	gdi_hb_state_t hb_next;
	logic [TMR_W-1:0] dt_reg;
	logic [TMR_W-1:0] dt_next;
	logic hb_run;

	always_comb
	begin
		hb_run = !direct && enable && clr_n;
		hb_next = hb_reg;
		dt_next = (dt_reg != '0) ? dt_reg - 8'h01 : dt_reg;
		if (!hb_run)
		begin
			hb_next = HB_OFF;
			dt_next = '0;
		end
		else
		begin
			unique case (hb_reg)
				// Enabling always passes through a dead time first
				HB_OFF:
				begin
					hb_next = pwm ? HB_DT2 : HB_DT1;
					dt_next = DEAD_CYC;
				end
				HB_CH1:
				begin
					if (pwm)
					begin
						hb_next = HB_DT2;
						dt_next = DEAD_CYC;
					end
				end
				HB_DT2:
				begin
					if (!pwm)
					begin
						hb_next = HB_DT1;
						dt_next = DEAD_CYC;
					end
					else if (dt_reg == 8'h01)
						hb_next = HB_CH2;
				end
				HB_CH2:
				begin
					if (!pwm)
					begin
						hb_next = HB_DT1;
						dt_next = DEAD_CYC;
					end
				end
				HB_DT1:
				begin
					if (pwm)
					begin
						hb_next = HB_DT2;
						dt_next = DEAD_CYC;
					end
					else if (dt_reg == 8'h01)
						hb_next = HB_CH1;
				end
				// A corrupted one-hot code falls back to both off
				default:
				begin
					hb_next = HB_OFF;
					dt_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			hb_reg <= HB_OFF;
			dt_reg <= '0;
		end
		else
		begin
			hb_reg <= hb_next;
			dt_reg <= dt_next;
		end
	end

	// Per-channel protection: blocking, response mask, memory, gate, LED
	logic [BLK_W-1:0] blk_reg [2];
	logic [BLK_W-1:0] blk_next [2];
	logic [TMR_W-1:0] rsp_reg [2];
	logic [TMR_W-1:0] rsp_next [2];
	logic [1:0] err_reg;
	logic [1:0] err_next;
	logic [1:0] gate_reg;
	logic [1:0] gate_next;
	logic [1:0] led_reg;
	logic [1:0] led_next;
	logic [1:0] cmd;
	logic [1:0] fault_now;
	logic [1:0] blocked;
	logic od_low_reg;

	always_comb
	begin
		// Direct mode passes both inputs with no interlock at all
		if (direct)
			cmd = drive;
		else
			cmd = {hb_reg == HB_CH2, hb_reg == HB_CH1};
		for (int i = 0; i < 2; i++)
		begin
			// Saturation only counts on a switch past its response time
			fault_now[i] = uv[i] || (sat[i] && gate_reg[i] && rsp_reg[i] == '0);
			blocked[i] = blk_reg[i] != '0;
			if (fault_now[i])
				blk_next[i] = BLOCK_CYC;
			else if (blocked[i])
				blk_next[i] = blk_reg[i] - 25'h0000001;
			else
				blk_next[i] = blk_reg[i];
			// A stored error or a block makes the channel ignore its drive
			gate_next[i] = cmd[i] && clr_n && !blocked[i] && !fault_now[i]
				&& !err_reg[i];
			if (gate_next[i] && !gate_reg[i])
				rsp_next[i] = RESP_CYC;
			else if (rsp_reg[i] != '0)
				rsp_next[i] = rsp_reg[i] - 8'h01;
			else
				rsp_next[i] = rsp_reg[i];
			led_next[i] = sup[i] && !blocked[i] && !fault_now[i];
		end
		// Clear held low overrides any edge in the same cycle
		if (!clr_n)
			err_next = 2'h0;
		else if (edge_seen && blocked == 2'h0)
			err_next = 2'h0;
		else if (edge_seen)
			err_next = err_reg | blocked;
		else
			err_next = err_reg;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			// Start-up counts as a fault so the first edge must wait out the block
			for (int i = 0; i < 2; i++)
			begin
				blk_reg[i] <= BLOCK_CYC;
				rsp_reg[i] <= '0;
			end
			err_reg <= ERR_RST;
			gate_reg <= 2'h0;
			led_reg <= 2'h0;
			od_low_reg <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				blk_reg[i] <= blk_next[i];
				rsp_reg[i] <= rsp_next[i];
			end
			err_reg <= err_next;
			gate_reg <= gate_next;
			led_reg <= led_next;
			od_low_reg <= 1'b0;
		end
	end

	// Open-drain status: drive low only while the memory is set
	assign o_fault_flag_ch1_o = od_low_reg;
	assign o_fault_flag_ch2_o = od_low_reg;
	assign o_fault_flag_ch1_oe = err_reg[0];
	assign o_fault_flag_ch2_oe = err_reg[1];
	assign o_gate_ch1 = gate_reg[0];
	assign o_gate_ch2 = gate_reg[1];
	assign o_led_ch1 = led_reg[0];
	assign o_led_ch2 = led_reg[1];

endmodule // gdi_gate_drive

/* File: core/gdi_pkg.sv */
/*
 * Shared constants for the two-channel gate drive input logic:
 * clock rate, dead time, response and blocking times, the layout of the
 * synchronised input vector and the half-bridge sequencer states.
 * Assumes a single 20 MHz clock domain.
 */
package gdi_pkg;

	localparam int unsigned CLK_FREQ_KHZ = 20000;

	// Fixed at build time; the host has no run-time control over it
	localparam int unsigned DEAD_TIME_NS = 1000;
	localparam int unsigned DEAD_CYC_RAW = (DEAD_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam logic [7:0] DEAD_CYC = (DEAD_CYC_RAW < 1) ? 8'h01 : DEAD_CYC_RAW[7:0];

	// Saturation monitoring stays blind this long after each turn-on
	localparam int unsigned RESP_TIME_NS = 4000;
	localparam int unsigned RESP_CYC_RAW = (RESP_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
	localparam logic [7:0] RESP_CYC = (RESP_CYC_RAW < 1) ? 8'h01 : RESP_CYC_RAW[7:0];

	// Blocking time after a fault, a longest time, so rounded down
	localparam int unsigned BLOCK_TIME_MS = 1000;
	localparam int unsigned BLOCK_CYC_DEF = BLOCK_TIME_MS * CLK_FREQ_KHZ;
	localparam int unsigned BLK_W = 25;
	localparam int unsigned TMR_W = 8;

	// Bit positions in the synchronised input vector
	localparam int unsigned SY_A = 0;
	localparam int unsigned SY_B = 1;
	localparam int unsigned SY_MODE = 2;
	localparam int unsigned SY_CLR_N = 3;
	localparam int unsigned SY_SAT1 = 4;
	localparam int unsigned SY_SAT2 = 5;
	localparam int unsigned SY_UV1 = 6;
	localparam int unsigned SY_UV2 = 7;
	localparam int unsigned SY_SUP1 = 8;
	localparam int unsigned SY_SUP2 = 9;
	localparam int unsigned SY_W = 10;
	// Idle levels of the pins: mode and clear pulled high, drives pulled low
	localparam logic [9:0] SY_RST = 10'h00c;

	localparam logic [1:0] ERR_RST = 2'h3;

	typedef enum logic [4:0] {
		HB_OFF = 5'h01,
		HB_CH1 = 5'h02,
		HB_DT2 = 5'h04,
		HB_CH2 = 5'h08,
		HB_DT1 = 5'h10
	} gdi_hb_state_t;

endpackage

/* File: core/gdi_sync3.sv */
/*
 * Three-stage input synchroniser with agreement filter, one bit per lane.
 * The output changes only once stages two and three agree.
 * Assumes inputs come from outside the clock domain; reset value per lane
 * is the level an unconnected pin settles to.
 */
`timescale 1ns/10ps
module gdi_sync3
#(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST = '0
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_next;

	// A lane moves only when the two settled stages agree
	always_comb
	begin
		q_next = (s2_reg & s3_reg) | (o_q & (s2_reg | s3_reg));
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s1_reg <= RST;
			s2_reg <= RST;
			s3_reg <= RST;
			o_q <= RST;
		end
		else
		begin
			s1_reg <= i_d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			o_q <= q_next;
		end
	end

endmodule // gdi_sync3

/* File: tb/gdi_checker.sv */
/* Port-level checks for the gate drive block.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/10ps
module gdi_checker
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_drive_input_a,
	input wire logic i_drive_input_b,
	input wire logic i_topology_sel,
	input wire logic i_fault_clear_n,
	input wire logic i_uv_fault_ch1,
	input wire logic i_converter_supply_ch2,
	input wire logic o_gate_ch1,
	input wire logic o_gate_ch2,
	input wire logic o_fault_flag_ch1_oe,
	input wire logic o_fault_flag_ch2_oe,
	input wire logic o_led_ch1,
	input wire logic o_led_ch2
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	chk_hb_excl: assert property ((!i_topology_sel)[*6] |-> !(o_gate_ch1 && o_gate_ch2))
		else $error("both gates on in half-bridge");
	chk_dead_gap: assert property (!i_topology_sel && !$past(i_topology_sel, 6)
		&& $fell(o_gate_ch1) |-> (!o_gate_ch2)[*8])
		else $error("channel 2 on inside dead time");
	chk_enable_off: assert property ((!i_drive_input_b && !i_topology_sel)[*7]
		|-> !o_gate_ch1 && !o_gate_ch2)
		else $error("gate on with enable low");
	chk_clear_off: assert property ((!i_fault_clear_n)[*6] |-> !o_gate_ch1 && !o_gate_ch2
		&& !o_fault_flag_ch1_oe && !o_fault_flag_ch2_oe)
		else $error("clear did not block and clear");
	chk_direct_follow: assert property ($rose(o_gate_ch1) && i_topology_sel
		|-> $past(i_drive_input_a, 4))
		else $error("direct gate rose without input");
	chk_flag_gate: assert property (o_fault_flag_ch1_oe |=> !o_gate_ch1)
		else $error("gate on with error stored");
	chk_led_supply: assert property ((!i_converter_supply_ch2)[*6] |-> !o_led_ch2)
		else $error("led lit without supply");
	chk_uv_block: assert property (i_uv_fault_ch1[*6] |-> !o_gate_ch1 && !o_led_ch1)
		else $error("undervoltage did not block");
endmodule // gdi_checker

bind gdi_gate_drive gdi_checker u_gdi_checker (
	.i_clk(i_clk),
	.i_rstn(i_rstn),
	.i_drive_input_a(i_drive_input_a),
	.i_drive_input_b(i_drive_input_b),
	.i_topology_sel(i_topology_sel),
	.i_fault_clear_n(i_fault_clear_n),
	.i_uv_fault_ch1(i_uv_fault_ch1),
	.i_converter_supply_ch2(i_converter_supply_ch2),
	.o_gate_ch1(o_gate_ch1),
	.o_gate_ch2(o_gate_ch2),
	.o_fault_flag_ch1_oe(o_fault_flag_ch1_oe),
	.o_fault_flag_ch2_oe(o_fault_flag_ch2_oe),
	.o_led_ch1(o_led_ch1),
	.o_led_ch2(o_led_ch2)
);

/* File: tb/gdi_host_model.sv */
/* Host control model: square PWM on drive input A while run is high.
   Assumes the bench keeps run low through the start-up wait. */
`timescale 1ns/10ps
module gdi_host_model
#(
	parameter int unsigned HALF = 40
)
(
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_pwm
);
	int cnt = 0;
	// No edges until released, so start-up blocking has expired
	always @(negedge i_clk)
	begin
		if (!i_run)
		begin
			cnt <= 0;
			o_pwm <= 1'b0;
		end
		else if (cnt == HALF - 1)
		begin
			cnt <= 0;
			o_pwm <= ~o_pwm;
		end
		else
			cnt <= cnt + 1;
	end
endmodule // gdi_host_model

/* File: tb/tb.sv */
/* Self-checking bench for the gate drive block.
   Assumes open-pin levels are driven by the bench. */
`timescale 1ns/10ps
module tb;
	localparam int BLK = 200;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic a_drv = 1'b0;
	logic run = 1'b0;
	logic pwm;
	wire logic i_drive_input_a;
	logic i_drive_input_b = 1'b0;
	logic i_topology_sel = 1'b1;
	logic i_fault_clear_n = 1'b1;
	logic i_sat_fault_ch1 = 1'b0;
	logic i_sat_fault_ch2 = 1'b0;
	logic i_uv_fault_ch1 = 1'b0;
	logic i_uv_fault_ch2 = 1'b0;
	logic i_converter_supply_ch1 = 1'b1;
	logic i_converter_supply_ch2 = 1'b1;
	logic o_gate_ch1, o_gate_ch2, o_led_ch1, o_led_ch2;
	logic o_fault_flag_ch1_o, o_fault_flag_ch1_oe, o_fault_flag_ch2_o, o_fault_flag_ch2_oe;
	int fail_count = 0;
	int num_checks = 0;
	wire logic [5:0] st = {o_gate_ch1, o_gate_ch2, o_fault_flag_ch1_oe, o_fault_flag_ch2_oe,
		o_led_ch1, o_led_ch2};
	// Pin levels with the pull-ups; the third bit is both outputs tied together
	wire logic so_ch1 = o_fault_flag_ch1_oe ? o_fault_flag_ch1_o : 1'b1;
	wire logic so_ch2 = o_fault_flag_ch2_oe ? o_fault_flag_ch2_o : 1'b1;
	wire logic [2:0] so_lvl = {so_ch1, so_ch2, so_ch1 & so_ch2};
	always #25 i_clk = ~i_clk;
	assign i_drive_input_a = run ? pwm : a_drv;
	gdi_gate_drive #(.P_BLOCK_CYC(BLK)) u_gdi_gate_drive (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_drive_input_a(i_drive_input_a),
		.i_drive_input_b(i_drive_input_b),
		.i_topology_sel(i_topology_sel),
		.i_fault_clear_n(i_fault_clear_n),
		.i_sat_fault_ch1(i_sat_fault_ch1),
		.i_sat_fault_ch2(i_sat_fault_ch2),
		.i_uv_fault_ch1(i_uv_fault_ch1),
		.i_uv_fault_ch2(i_uv_fault_ch2),
		.i_converter_supply_ch1(i_converter_supply_ch1),
		.i_converter_supply_ch2(i_converter_supply_ch2),
		.o_gate_ch1(o_gate_ch1),
		.o_gate_ch2(o_gate_ch2),
		.o_fault_flag_ch1_o(o_fault_flag_ch1_o),
		.o_fault_flag_ch1_oe(o_fault_flag_ch1_oe),
		.o_fault_flag_ch2_o(o_fault_flag_ch2_o),
		.o_fault_flag_ch2_oe(o_fault_flag_ch2_oe),
		.o_led_ch1(o_led_ch1),
		.o_led_ch2(o_led_ch2)
	);
	gdi_host_model u_gdi_host_model (.i_clk(i_clk), .i_run(run), .o_pwm(pwm));
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		cyc(12);
		chk(st, 6'h0c);
		chk({3'h0, so_lvl}, 6'h00);
		i_rstn = 1'b1;
		cyc(BLK + 10);
		chk(st, 6'h0f);
		$display("startup done");
		a_drv = 1'b1;
		cyc(8);
		chk(st, 6'h23);
		chk({3'h0, so_lvl}, 6'h07);
		i_drive_input_b = 1'b1;
		cyc(8);
		chk(st, 6'h33);
		i_fault_clear_n = 1'b0;
		cyc(6);
		chk(st, 6'h03);
		i_fault_clear_n = 1'b1;
		cyc(8);
		chk(st, 6'h33);
		a_drv = 1'b0;
		i_drive_input_b = 1'b0;
		cyc(8);
		chk(st, 6'h03);
		$display("direct done");
		i_topology_sel = 1'b0;
		i_drive_input_b = 1'b1;
		cyc(30);
		chk(st, 6'h23);
		a_drv = 1'b1;
		cyc(6);
		chk(st, 6'h03);
		cyc(25);
		chk(st, 6'h13);
		a_drv = 1'b0;
		cyc(6);
		chk(st, 6'h03);
		cyc(25);
		chk(st, 6'h23);
		run = 1'b1;
		cyc(400);
		run = 1'b0;
		cyc(30);
		i_drive_input_b = 1'b0;
		cyc(8);
		chk(st, 6'h03);
		$display("halfbridge done");
		i_topology_sel = 1'b1;
		a_drv = 1'b1;
		cyc(8);
		chk(st, 6'h23);
		i_uv_fault_ch1 = 1'b1;
		cyc(8);
		chk(st, 6'h01);
		i_uv_fault_ch1 = 1'b0;
		a_drv = 1'b0;
		cyc(8);
		chk(st, 6'h09);
		chk({3'h0, so_lvl}, 6'h02);
		cyc(BLK);
		chk(st, 6'h0b);
		a_drv = 1'b1;
		cyc(8);
		chk(st, 6'h23);
		i_sat_fault_ch1 = 1'b1;
		cyc(20);
		chk(st, 6'h23);
		cyc(80);
		chk(st, 6'h01);
		i_sat_fault_ch1 = 1'b0;
		i_uv_fault_ch2 = 1'b1;
		cyc(8);
		chk(st, 6'h00);
		i_uv_fault_ch2 = 1'b0;
		cyc(BLK + 8);
		chk(st, 6'h23);
		i_converter_supply_ch2 = 1'b0;
		cyc(6);
		chk(st, 6'h22);
		$display("faults done");
		give_verdict();
	end
	initial
	begin
		repeat (3000) @(posedge i_clk);
		fail_count++;
		give_verdict();
	end
endmodule // tb
